// file: charger_option_control.sv
/*
 Charger option control word behind the serial word interface, with the
 communication watchdog, overvoltage latch and decoded control outputs.
 Assumes pin inputs synchronous to clk_i and analog loops outside.
*/
// Notes on behaviour
// R1: Option command code writes the option word
// R2: Word transfers, fixed address, low byte first
// R3: Watchdog expiry without voltage/current write suspends charge
// R4: Voltage or current write resumes suspended charge
// R5: Watchdog codes: off, 44, 88, 175 s
// R6: Low-power bit acts only on battery
// R7: Overvoltage latches converter off; threshold select bit
// R8: Overvoltage status read-only, cleared by writing zero
// R9: Audio limit bit; frequency code 11 means 800k
// R10: Adapter overcurrent enable bit, 333 percent threshold
// R11: Low-side switch threshold bit, 250/350 mV
// R12: Battery_discharge_a bit stops converter, battery switch on
// R13: Fix bit clear: monitor follows input limit enable
// R14: Fix bit set: select bit picks amplifier
// R15: Fix bit clear: select bit reads as status
// R16: Linear precharge bit; off turns battery switch on
// R17: Input limit enable, charge inhibit plain bits
`timescale 1ns/1ps
`default_nettype none
module charger_option_control #(
   parameter int unsigned SEC_CYCLES = charger_option_pkg::CLK_HZ * charger_option_pkg::TICK_S
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Serial bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Status from the power stage
   input wire logic on_battery_i,
   input wire logic sys_ovp_detect_i,
   // Controls to the power stage
   output logic battery_low_quiescent_sel_o,
   output logic charge_suspend_o,
   output logic ovp_threshold_high_o,
   output logic converter_latch_off_o,
   output logic audio_limit_o,
   output logic [1:0] switching_freq_o,
   output logic adapter_overcurrent_o,
   output logic low_side_switch_ocp_high_o,
   output logic battery_discharge_a_o,
   output logic converter_enable_o,
   output logic battery_switch_on_o,
   output logic current_monitor_output_sel_o,
   output logic linear_precharge_o,
   output logic input_limit_enable_o,
   output logic charge_enable_o
);
   localparam int DIV_W = $clog2(SEC_CYCLES);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SEC_CYCLES - 1);

   // Serial engine hand-over
   logic [7:0] cmd; // Latched command byte
   logic wr_stb; // One-cycle write of a full word
   logic [15:0] wr_data; // Written word
   logic [15:0] rd_data; // Word returned on reads

   // Stored word and its read view
   logic [15:0] opt_q, opt_d; // Option word
   logic [15:0] readback; // Option word as seen by a read
   logic opt_wr; // Write to the option word
   logic kick; // Voltage or current write

   // Watchdog timing
   logic [1:0] wdt_code; // Watchdog field
   logic [7:0] wdt_limit; // Timeout in seconds
   logic [DIV_W-1:0] div_q; // Second divider
   logic tick; // One-second enable pulse
   logic [7:0] sec_q; // Seconds since last kick
   logic suspend_q; // Watchdog suspended charging

   logic mon_sel; // Effective monitor selection

   // Serial engine
   smbus_word_slave #(
      .ADDR(charger_option_pkg::DEV_ADDR)
   ) u_slave (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe_o(sda_oe_o),
      .cmd_o(cmd),
      .wr_stb_o(wr_stb),
      .wr_data_o(wr_data),
      .rd_data_i(rd_data)
   );

   // Command decode
   assign opt_wr = wr_stb && cmd == charger_option_pkg::CMD_OPTION; // [R1]
   assign kick = wr_stb && (cmd == charger_option_pkg::CMD_CHG_CURRENT ||
                            cmd == charger_option_pkg::CMD_CHG_VOLTAGE); // [R4]

   // Monitor selection follows limit enable unless fixed
   assign mon_sel = opt_q[charger_option_pkg::BIT_FIX] ?
                    opt_q[charger_option_pkg::BIT_MONSEL] : // [R14]
                    opt_q[charger_option_pkg::BIT_ILIM]; // [R13]

   // Read view: select bit shows status when not fixed
   // Other commands read as zero; only this word lives here
   always_comb begin
      readback = opt_q;
      readback[charger_option_pkg::BIT_MONSEL] = mon_sel; // [R15]
      rd_data = (cmd == charger_option_pkg::CMD_OPTION) ? readback : 16'h0000;
   end

   // Next option word; status bit cannot be set by software
   always_comb begin
      opt_d = opt_q;
      if (opt_wr) opt_d = wr_data; // [R1] [R17]
      // Detection wins over a clearing write [R8]
      opt_d[charger_option_pkg::BIT_OVP_STAT] = sys_ovp_detect_i |
         (opt_q[charger_option_pkg::BIT_OVP_STAT] &
          ~(opt_wr & ~wr_data[charger_option_pkg::BIT_OVP_STAT]));
   end

   // Option word storage
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) opt_q <= charger_option_pkg::OPT_RESET;
      else opt_q <= opt_d;
   end

   // Watchdog period decode [R5]
   // Code 00 lands on the default but never counts
   assign wdt_code = opt_q[charger_option_pkg::WDT_HI:charger_option_pkg::WDT_LO];
   always_comb begin
      unique case (wdt_code)
         charger_option_pkg::WDT_44: wdt_limit = charger_option_pkg::WDT_44_S;
         charger_option_pkg::WDT_88: wdt_limit = charger_option_pkg::WDT_88_S;
         default: wdt_limit = charger_option_pkg::WDT_175_S;
      endcase
   end

   // One-second divider; restarts on a kick so the period is not short
   // Wide counter traded for a single clock domain
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) div_q <= '0;
      else if (kick || div_q == DIV_LAST) div_q <= '0;
      else div_q <= div_q + DIV_W'(1);
   end
   assign tick = (div_q == DIV_LAST) && !kick;

   // Seconds counter, frozen while suspended, cleared while disabled
   // Freezing keeps a suspension from firing twice
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) sec_q <= 8'h00;
      else if (kick || wdt_code == charger_option_pkg::WDT_OFF) sec_q <= 8'h00;
      else if (tick && !suspend_q) sec_q <= sec_q + 8'h01;
   end

   // Suspend on expiry, resume on a kick [R3] [R4]
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) suspend_q <= 1'h0;
      else if (kick || wdt_code == charger_option_pkg::WDT_OFF) suspend_q <= 1'h0;
      else if (tick && sec_q + 8'h01 >= wdt_limit) suspend_q <= 1'h1;
   end

   // Registered controls to the power stage
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         // Inactive, frequency at 800k, until the first edge after reset
         battery_low_quiescent_sel_o <= 1'h0;
         charge_suspend_o <= 1'h0;
         ovp_threshold_high_o <= 1'h0;
         converter_latch_off_o <= 1'h0;
         audio_limit_o <= 1'h0;
         switching_freq_o <= charger_option_pkg::FREQ_800K;
         adapter_overcurrent_o <= 1'h0;
         low_side_switch_ocp_high_o <= 1'h0;
         battery_discharge_a_o <= 1'h0;
         converter_enable_o <= 1'h0;
         battery_switch_on_o <= 1'h0;
         current_monitor_output_sel_o <= 1'h0;
         linear_precharge_o <= 1'h0;
         input_limit_enable_o <= 1'h0;
         charge_enable_o <= 1'h0;
      end else begin
         // Quiescent saving only matters without adapter [R6]
         battery_low_quiescent_sel_o <= opt_q[charger_option_pkg::BIT_LOWPWR] & on_battery_i;
         charge_suspend_o <= suspend_q; // [R3]
         ovp_threshold_high_o <= opt_q[charger_option_pkg::BIT_OVP_SEL]; // [R7]
         converter_latch_off_o <= opt_q[charger_option_pkg::BIT_OVP_STAT]; // [R7]
         audio_limit_o <= opt_q[charger_option_pkg::BIT_AUDIO]; // [R9]
         // Spare code runs at the default rate [R9]
         if (opt_q[charger_option_pkg::FREQ_HI:charger_option_pkg::FREQ_LO] ==
             charger_option_pkg::FREQ_SPARE)
            switching_freq_o <= charger_option_pkg::FREQ_800K;
         else
            switching_freq_o <= opt_q[charger_option_pkg::FREQ_HI:charger_option_pkg::FREQ_LO];

         // Protection thresholds for the analog side
         adapter_overcurrent_o <= opt_q[charger_option_pkg::BIT_ADP_OC]; // [R10]
         low_side_switch_ocp_high_o <= opt_q[charger_option_pkg::BIT_LSOCP]; // [R11]

         // Battery_discharge_a mode: buck off, battery carries load
         battery_discharge_a_o <= opt_q[charger_option_pkg::BIT_BATTERY_DISCHARGE_A]; // [R12]
         // Battery_discharge_a mode and the overvoltage latch both stop the buck [R12] [R7]
         converter_enable_o <= ~opt_q[charger_option_pkg::BIT_BATTERY_DISCHARGE_A] &
                               ~opt_q[charger_option_pkg::BIT_OVP_STAT];
         // Pack handles precharge when the linear mode is off [R16] [R12]
         battery_switch_on_o <= opt_q[charger_option_pkg::BIT_BATTERY_DISCHARGE_A] |
                                ~opt_q[charger_option_pkg::BIT_LIN_PRE];

         // Monitor routing and precharge mode
         current_monitor_output_sel_o <= mon_sel; // [R13] [R14]
         linear_precharge_o <= opt_q[charger_option_pkg::BIT_LIN_PRE]; // [R16]

         // Plain stored bits; inhibit and watchdog gate charge
         input_limit_enable_o <= opt_q[charger_option_pkg::BIT_ILIM]; // [R17]
         charge_enable_o <= ~opt_q[charger_option_pkg::BIT_INHIBIT] & ~suspend_q; // [R17]
      end
   end

   // Checks on the block's own behaviour
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   // Option write strobe
   sequence s_opt_write;
      wr_stb && cmd == charger_option_pkg::CMD_OPTION;
   endsequence

   // Watchdog kick strobe
   sequence s_kick;
      wr_stb && (cmd == charger_option_pkg::CMD_CHG_CURRENT ||
                 cmd == charger_option_pkg::CMD_CHG_VOLTAGE);
   endsequence

   // Written bits land, status aside
   a_opt_store: assert property (s_opt_write |=> // [R1]
      opt_q[15:12] == $past(wr_data[15:12]) && opt_q[10:0] == $past(wr_data[10:0]))
      else $error("option write not stored");

   // Detection reaches the latch output
   a_ovp_set: assert property (sys_ovp_detect_i |=> ##1 converter_latch_off_o) // [R7]
      else $error("overvoltage did not latch converter off");

   // Status sticks until cleared
   a_ovp_hold: assert property (opt_q[charger_option_pkg::BIT_OVP_STAT] && // [R8]
      !(opt_wr && !wr_data[charger_option_pkg::BIT_OVP_STAT])
      |=> opt_q[charger_option_pkg::BIT_OVP_STAT])
      else $error("overvoltage status lost without clearing write");

   // Status never set by a write
   a_ovp_nowrite: assert property (!opt_q[charger_option_pkg::BIT_OVP_STAT] && // [R8]
      !sys_ovp_detect_i |=> !opt_q[charger_option_pkg::BIT_OVP_STAT])
      else $error("overvoltage status set without detection");

   // Kick lifts a suspension
   a_wdt_resume: assert property (s_kick |=> ##1 !charge_suspend_o && charge_enable_o == // [R4]
      !opt_q[charger_option_pkg::BIT_INHIBIT])
      else $error("charge not resumed after kick");

   // Disabled watchdog never suspends
   a_wdt_off: assert property (wdt_code == charger_option_pkg::WDT_OFF [*2] // [R5]
      |=> !charge_suspend_o)
      else $error("suspend while watchdog disabled");

   // Last tick of the period suspends
   a_wdt_expire: assert property (tick && !kick && sec_q == wdt_limit - 8'h01 && // [R3]
      wdt_code != charger_option_pkg::WDT_OFF |=> ##1 charge_suspend_o)
      else $error("watchdog expiry did not suspend");

   // Monitor routing, fixed or following
   a_mon_route: assert property (##1 current_monitor_output_sel_o == // [R13]
      $past(opt_q[charger_option_pkg::BIT_FIX] ? opt_q[charger_option_pkg::BIT_MONSEL]
                                                : opt_q[charger_option_pkg::BIT_ILIM]))
      else $error("monitor selection wrong");

   // Battery_discharge_a mode stops the buck
   a_battery_discharge_a_stop: assert property (opt_q[charger_option_pkg::BIT_BATTERY_DISCHARGE_A] // [R12]
      |=> !converter_enable_o && battery_switch_on_o)
      else $error("battery_discharge_a mode did not stop converter");

   // Spare code runs at the default rate
   a_freq_alias: assert property ( // [R9]
      opt_q[charger_option_pkg::FREQ_HI:charger_option_pkg::FREQ_LO] ==
      charger_option_pkg::FREQ_SPARE
      |=> switching_freq_o == charger_option_pkg::FREQ_800K)
      else $error("spare frequency code not mapped");

   // Adapter power overrides low power
   a_lowpwr_bat: assert property (!on_battery_i |=> !battery_low_quiescent_sel_o) // [R6]
      else $error("low power active on adapter");

   // Other commands never touch the word
   a_other_cmd: assert property (wr_stb && cmd != charger_option_pkg::CMD_OPTION && // [R1]
      !sys_ovp_detect_i |=> opt_q == $past(opt_q))
      else $error("option word changed by another command");

   // Inhibit holds charging off
   a_inhibit: assert property (opt_q[charger_option_pkg::BIT_INHIBIT] // [R17]
      |=> !charge_enable_o)
      else $error("charge enabled while inhibited");
endmodule
`default_nettype wire

// file: charger_option_pkg.sv
/*
 Shared constants for the charger option control block: bus address,
 command codes, option bit positions, reset value and watchdog timing.
 Assumes a single 20 MHz clock domain.
*/
`default_nettype none
package charger_option_pkg;
   // Bus identity and command codes
   localparam logic [6:0] DEV_ADDR = 7'h09;
   localparam logic [7:0] CMD_OPTION = 8'h12;
   localparam logic [7:0] CMD_CHG_CURRENT = 8'h14;
   localparam logic [7:0] CMD_CHG_VOLTAGE = 8'h15;
   // Power-on value of the option word
   localparam logic [15:0] OPT_RESET = 16'hE144;
   // Option bit positions
   localparam int BIT_LOWPWR = 15;
   localparam int WDT_HI = 14;
   localparam int WDT_LO = 13;
   localparam int BIT_OVP_SEL = 12;
   localparam int BIT_OVP_STAT = 11;
   localparam int BIT_AUDIO = 10;
   localparam int FREQ_HI = 9;
   localparam int FREQ_LO = 8;
   localparam int BIT_ADP_OC = 7;
   localparam int BIT_LSOCP = 6;
   localparam int BIT_BATTERY_DISCHARGE_A = 5;
   localparam int BIT_MONSEL = 4;
   localparam int BIT_FIX = 3;
   localparam int BIT_LIN_PRE = 2;
   localparam int BIT_ILIM = 1;
   localparam int BIT_INHIBIT = 0;
   // Watchdog codes and periods in seconds
   localparam logic [1:0] WDT_OFF = 2'h0;
   localparam logic [1:0] WDT_44 = 2'h1;
   localparam logic [1:0] WDT_88 = 2'h2;
   localparam logic [7:0] WDT_44_S = 8'h2C;
   localparam logic [7:0] WDT_88_S = 8'h58;
   localparam logic [7:0] WDT_175_S = 8'hAF;
   // Frequency codes: the spare code aliases the default
   localparam logic [1:0] FREQ_SPARE = 2'h3;
   localparam logic [1:0] FREQ_800K = 2'h1;
   // Clock rate and the watchdog tick period in seconds
   localparam int CLK_HZ = 20000000;
   localparam int TICK_S = 1;
   // Receive byte length and byte phases
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [1:0] PH_ADDR = 2'h0;
   localparam logic [1:0] PH_CMD = 2'h1;
   localparam logic [1:0] PH_LO = 2'h2;
   localparam logic [1:0] PH_HI = 2'h3;
   // Serial engine states
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_RX = 5'h02,
      S_ACK = 5'h04,
      S_TX = 5'h08,
      S_RACK = 5'h10
   } smb_state_t;
endpackage
`default_nettype wire

// file: smbus_word_slave.sv
/*
 Word-transfer serial slave: takes Write-Word and Read-Word frames,
 hands out a write strobe with command and data, returns read data.
 Assumes scl_i and sda_i are already synchronous to clk_i and that the
 clock is well above the bus bit rate.
*/
`timescale 1ns/1ps
`default_nettype none
module smbus_word_slave #(
   parameter logic [6:0] ADDR = charger_option_pkg::DEV_ADDR
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Bus pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Register side
   output logic [7:0] cmd_o,
   output logic wr_stb_o,
   output logic [15:0] wr_data_o,
   input wire logic [15:0] rd_data_i
);
   charger_option_pkg::smb_state_t state_q;
   logic scl_q, sda_q; // Previous pin samples
   logic [3:0] cnt_q; // Bits in current byte
   logic [7:0] sh_q; // Shift register
   logic [1:0] phase_q; // Which byte of the frame
   logic rw_q; // Read requested
   logic full_q; // Word already taken
   logic txhi_q; // Sending high byte
   logic [7:0] lo_q; // Held low data byte
   logic start, stop, rise, fall;

   // Pin history for edge and condition detection
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q <= 1'h1;
         sda_q <= 1'h1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   assign start = scl_i & scl_q & sda_q & ~sda_i;
   assign stop = scl_i & scl_q & ~sda_q & sda_i;
   assign rise = scl_i & ~scl_q;
   assign fall = ~scl_i & scl_q;

   // Open drain: only ever pulls low
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) sda_o <= 1'h0;
      else sda_o <= 1'h0;
   end

   // Frame engine; low byte first, then high byte [R2]
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= charger_option_pkg::S_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         phase_q <= charger_option_pkg::PH_ADDR;
         rw_q <= 1'h0;
         full_q <= 1'h0;
         txhi_q <= 1'h0;
         lo_q <= 8'h00;
         cmd_o <= 8'h00;
         wr_stb_o <= 1'h0;
         wr_data_o <= 16'h0000;
         sda_oe_o <= 1'h0;
      end else begin
         wr_stb_o <= 1'h0;
         if (start) begin
            // Repeated start keeps the command byte
            state_q <= charger_option_pkg::S_RX;
            cnt_q <= 4'h0;
            phase_q <= charger_option_pkg::PH_ADDR;
            full_q <= 1'h0;
            sda_oe_o <= 1'h0;
         end else if (stop) begin
            state_q <= charger_option_pkg::S_IDLE;
            sda_oe_o <= 1'h0;
         end else begin
            unique case (state_q)
               charger_option_pkg::S_IDLE: begin
               end
               charger_option_pkg::S_RX: begin
                  if (rise) begin
                     sh_q <= {sh_q[6:0], sda_i};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (fall && cnt_q == charger_option_pkg::BYTE_BITS) begin
                     cnt_q <= 4'h0;
                     state_q <= charger_option_pkg::S_ACK;
                     sda_oe_o <= 1'h1;
                     if (phase_q != charger_option_pkg::PH_HI) phase_q <= phase_q + 2'h1;
                     unique case (phase_q)
                        charger_option_pkg::PH_ADDR: begin
                           // Foreign address: stay off the bus [R2]
                           if (sh_q[7:1] != ADDR) begin
                              state_q <= charger_option_pkg::S_IDLE;
                              sda_oe_o <= 1'h0;
                           end
                           rw_q <= sh_q[0];
                        end
                        charger_option_pkg::PH_CMD: cmd_o <= sh_q;
                        charger_option_pkg::PH_LO: lo_q <= sh_q;
                        charger_option_pkg::PH_HI: begin
                           // Bytes past the word are refused
                           if (full_q) begin
                              state_q <= charger_option_pkg::S_IDLE;
                              sda_oe_o <= 1'h0;
                           end else begin
                              wr_stb_o <= 1'h1;
                              wr_data_o <= {sh_q, lo_q};
                              full_q <= 1'h1;
                           end
                        end
                     endcase
                  end
               end
               charger_option_pkg::S_ACK: begin
                  if (fall) begin
                     if (rw_q) begin
                        state_q <= charger_option_pkg::S_TX;
                        sh_q <= rd_data_i[7:0];
                        sda_oe_o <= ~rd_data_i[7];
                        txhi_q <= 1'h0;
                     end else begin
                        state_q <= charger_option_pkg::S_RX;
                        sda_oe_o <= 1'h0;
                     end
                  end
               end
               charger_option_pkg::S_TX: begin
                  if (fall) begin
                     cnt_q <= cnt_q + 4'h1;
                     if (cnt_q == charger_option_pkg::BYTE_BITS - 4'h1) begin
                        sda_oe_o <= 1'h0;
                        state_q <= charger_option_pkg::S_RACK;
                     end else begin
                        sh_q <= {sh_q[6:0], 1'h0};
                        sda_oe_o <= ~sh_q[6];
                     end
                  end
               end
               charger_option_pkg::S_RACK: begin
                  // Master acknowledge sampled into bit 0
                  if (rise) sh_q[0] <= sda_i;
                  else if (fall) begin
                     cnt_q <= 4'h0;
                     if (!sh_q[0] && !txhi_q) begin
                        state_q <= charger_option_pkg::S_TX;
                        sh_q <= rd_data_i[15:8];
                        sda_oe_o <= ~rd_data_i[15];
                        txhi_q <= 1'h1;
                     end else state_q <= charger_option_pkg::S_IDLE;
                  end
               end
               default: state_q <= charger_option_pkg::S_IDLE;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: smbus_host_model.sv
/*
 Host model for the word serial bus: start, stop, bit and byte timing,
 Write-Word and Read-Word frames.
 Assumes a pulled-up data wire that the device only pulls low.
*/
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model #(
   parameter logic [6:0] ADDR = charger_option_pkg::DEV_ADDR
) (
   // Clock
   input wire logic clk_i,
   // Device data driver
   input wire logic dev_sda_i,
   input wire logic dev_oe_i,
   // Resolved bus lines
   output logic scl_o,
   output logic sda_o
);
   logic drv_q = 1'b1; // Host data drive, 1 releases the wire
   int half = 4; // Clocks per half bit, raised for slow frames
   initial scl_o = 1'b1;
   // Wired-and with pull-up: the wire never holds a stale value
   assign sda_o = drv_q & ~(dev_oe_i & ~dev_sda_i);
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // One bit; data moves only while the bus clock is low
   task automatic bit_io(input logic b, output logic r);
      wt(1);
      drv_q <= b;
      wt(half);
      scl_o <= 1'b1;
      wt(half / 2);
      @(negedge clk_i);
      r = sda_o;
      wt(half - half / 2);
      scl_o <= 1'b0;
   endtask
   // Start when st is 1, stop when 0
   task automatic cond(input logic st);
      wt(1);
      drv_q <= st;
      wt(half);
      scl_o <= 1'b1;
      wt(half);
      drv_q <= ~st;
      wt(half);
      scl_o <= ~st;
      wt(half);
   endtask
   // Byte MSB first, then the ninth bit: a is sent, r is seen
   task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic r);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(a, r);
   endtask
   task automatic write_word(input logic [6:0] ad, input logic [7:0] c,
                             input logic [15:0] w, output logic nak);
      logic [7:0] b [4];
      logic [7:0] q;
      logic r;
      b = '{{ad, 1'b0}, c, w[7:0], w[15:8]};
      nak = 1'b0;
      cond(1'b1);
      for (int i = 0; i < 4; i++) begin
         xbyte(b[i], 1'b1, q, r);
         nak = nak | r;
      end
      cond(1'b0);
   endtask
   task automatic read_word(input logic [7:0] c, output logic [15:0] w);
      logic [7:0] q;
      logic r;
      cond(1'b1);
      xbyte({ADDR, 1'b0}, 1'b1, q, r);
      xbyte(c, 1'b1, q, r);
      cond(1'b1);
      xbyte({ADDR, 1'b1}, 1'b1, q, r);
      xbyte(8'hFF, 1'b0, w[7:0], r); // Low byte first, acked
      xbyte(8'hFF, 1'b1, w[15:8], r); // High byte, nacked to end
      cond(1'b0);
   endtask
endmodule
`default_nettype wire

// file: charger_option_control_tb.sv
/*
 Self-checking bench for the charger option word: access, decoded
 outputs, overvoltage latch and watchdog timing.
 Assumes smbus_host_model and a 20-clock second.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module charger_option_control_tb;
   localparam int SEC = 20; // Short second keeps watchdog runs brief
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic on_battery_i = 1'b0;
   logic sys_ovp_detect_i = 1'b0;
   logic scl, sda, dev_sda, dev_oe, nak;
   wire logic [15:0] outs; // Outputs packed high to low as ports below
   logic [15:0] rd;
   int failures = 0;
   int cmp_count = 0;
   int per [4] = '{175, 44, 88, 175}; // Seconds; code 00 waits longest
   charger_option_control #(.SEC_CYCLES(SEC)) charger_option_control_inst (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(dev_sda),
      .sda_oe_o(dev_oe), .on_battery_i(on_battery_i), .sys_ovp_detect_i(sys_ovp_detect_i),
      .battery_low_quiescent_sel_o(outs[15]), .charge_suspend_o(outs[14]),
      .ovp_threshold_high_o(outs[13]), .converter_latch_off_o(outs[12]),
      .audio_limit_o(outs[11]), .switching_freq_o(outs[10:9]),
      .adapter_overcurrent_o(outs[8]), .low_side_switch_ocp_high_o(outs[7]),
      .battery_discharge_a_o(outs[6]), .converter_enable_o(outs[5]),
      .battery_switch_on_o(outs[4]), .current_monitor_output_sel_o(outs[3]),
      .linear_precharge_o(outs[2]), .input_limit_enable_o(outs[1]),
      .charge_enable_o(outs[0]));
   smbus_host_model host_inst (.clk_i(clk_i), .dev_sda_i(dev_sda), .dev_oe_i(dev_oe),
      .scl_o(scl), .sda_o(sda));
   // Clock at 20 MHz
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   // Wait n edges, then step past the edge's updates
   task automatic pass(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] v);
      host_inst.write_word(charger_option_pkg::DEV_ADDR, c, v, nak);
      `CHK("ack", 1'b0, nak);
   endtask
   task automatic rdchk(input logic [15:0] e);
      host_inst.read_word(charger_option_pkg::CMD_OPTION, rd);
      `CHK("option", e, rd);
   endtask
   task automatic look(input logic [15:0] e);
      pass(3);
      `CHK("outputs", e, outs);
   endtask
   task automatic final_report;
      if (failures == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Hang guard, well past the expected run of about 20k clocks
   initial begin
      repeat (60000) @(posedge clk_i);
      failures++;
      final_report();
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge clk_i);
      rst_b_i <= 1'b1;
      look(16'h02A5);
      rdchk(16'hE144);
      @(posedge clk_i) on_battery_i <= 1'b1;
      look(16'h82A5);
      wr(charger_option_pkg::CMD_OPTION, 16'h1FBB);
      look(16'h2B5A);
      rdchk(16'h17BB);
      wr(charger_option_pkg::CMD_OPTION, 16'h0002);
      look(16'h003B);
      rdchk(16'h0012);
      // Overvoltage pulse sets the latch; a zero write clears it
      @(posedge clk_i) sys_ovp_detect_i <= 1'b1;
      pass(2);
      @(posedge clk_i) sys_ovp_detect_i <= 1'b0;
      look(16'h101B);
      rdchk(16'h0812);
      wr(charger_option_pkg::CMD_OPTION, 16'h0002);
      look(16'h003B);
      // Foreign address is ignored; other commands leave the word alone
      host_inst.write_word(7'h0A, charger_option_pkg::CMD_OPTION, 16'hFFFF, nak);
      `CHK("foreign", 1'b1, nak);
      host_inst.half = 9;
      wr(8'h3E, 16'hFFFF);
      host_inst.read_word(8'h3E, rd);
      `CHK("other", 16'h0000, rd);
      host_inst.half = 4;
      rdchk(16'h0012);
      // Each watchdog code, and each frequency code with it
      for (int c = 0; c < 4; c++) begin
         wr(charger_option_pkg::CMD_OPTION, 16'(16'h0044 | (c << 13) | (c << 8)));
         wr(charger_option_pkg::CMD_CHG_CURRENT, 16'h0100);
         pass(3);
         `CHK("freq", 2'(c == 3 ? 1 : c), outs[10:9]);
         pass(per[c] * SEC - 60);
         `CHK("early", 2'b01, {outs[14], outs[0]});
         pass(120);
         `CHK("expiry", {1'(c != 0), 1'(c == 0)}, {outs[14], outs[0]});
         wr(charger_option_pkg::CMD_CHG_VOLTAGE, 16'h3000);
         pass(3);
         `CHK("resume", 2'b01, {outs[14], outs[0]});
      end
      final_report();
   end
endmodule
`default_nettype wire
